// File: gpdlm_regs.vh
`ifndef GPDLM_REGS_VH
`define GPDLM_REGS_VH
// register byte offsets
`define GPDLM_OFS_PORT_A_DATA_DATA 8'h00
`define GPDLM_OFS_PORT_A_DATA_DIR 8'h04
`define GPDLM_OFS_ANA_LOW 8'h08
`define GPDLM_OFS_PWR_CTRL 8'h0c
`define GPDLM_OFS_PORT_B_DATA_DATA 8'h10
`define GPDLM_OFS_PORT_B_DATA_DIR 8'h14
`define GPDLM_OFS_ANA_HIGH 8'h18
`define GPDLM_OFS_OSC_CFG 8'h1c
`define GPDLM_OFS_PERIPH_CTRL 8'h20
`define GPDLM_OFS_BIT_MODIFY 8'h24
// reset values
`define GPDLM_RST_LATCH 8'h00
`define GPDLM_RST_DIR 8'hff
`define GPDLM_RST_ANA_LOW 8'hff
`define GPDLM_RST_ANA_HIGH 6'h3f
`define GPDLM_RST_PWR 8'h00
`define GPDLM_RST_OSC 3'h4
`define GPDLM_RST_PERIPH 3'h0
// power control fields
`define GPDLM_PWR_WAKE_BIT 5
`define GPDLM_PWR_MASK 8'h33
// peripheral control fields
`define GPDLM_PER_C1OE_BIT 0
`define GPDLM_PER_C2OE_BIT 1
`define GPDLM_PER_COMPARATOR_REF_OUT_BIT 2
// bit modify fields
`define GPDLM_BM_IDX_MSB 2
`define GPDLM_BM_VAL_BIT 3
`define GPDLM_BM_PORT_BIT 8
// oscillator modes
`define GPDLM_OSC_LP 3'h0
`define GPDLM_OSC_XT 3'h1
`define GPDLM_OSC_HS 3'h2
`define GPDLM_OSC_EC 3'h3
`define GPDLM_OSC_INTIO 3'h4
`define GPDLM_OSC_INTCLKOUT 3'h5
`define GPDLM_OSC_RCIO 3'h6
`define GPDLM_OSC_RCCLKOUT 3'h7
`endif

// File: gpdlm_pin_cell.v
`timescale 1ns/10ps
module gpdlm_pin_cell #(
  parameter WIDTH = 8
) (
  input wire core_clk,
  input wire rstn,
  input wire [WIDTH-1:0] latchVal,
  input wire [WIDTH-1:0] dirVal,
  input wire [WIDTH-1:0] anaMask,
  input wire [WIDTH-1:0] ovrEn,
  input wire [WIDTH-1:0] ovrOut,
  input wire [WIDTH-1:0] ovrOe,
  input wire [WIDTH-1:0] forceOff,
  input wire [WIDTH-1:0] pinIn,
  output reg [WIDTH-1:0] pinOut,
  output reg [WIDTH-1:0] pinOe,
  output wire [WIDTH-1:0] rdVal
);
  // analog pins read zero
  assign rdVal = pinIn & ~anaMask;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : gPin
      always @(posedge core_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          pinOut[i] <= 1'b0;
          pinOe[i] <= 1'b0;
        end
        else if (ovrEn[i])
        begin
          pinOut[i] <= ovrOut[i];
          pinOe[i] <= ovrOe[i];
        end
        else
        begin
          pinOut[i] <= latchVal[i];
          pinOe[i] <= ~dirVal[i] & ~forceOff[i];
        end
      end
    end
  endgenerate
endmodule // gpdlm_pin_cell

// File: gpdlm_port.v
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "gpdlm_regs.vh"
module gpdlm_port (
  input wire core_clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] pinAIn,
  output wire [7:0] pinAOut,
  output wire [7:0] pinAOe,
  input wire [7:0] pinBIn,
  output wire [7:0] pinBOut,
  output wire [7:0] pinBOe,
  input wire [7:0] periphBOvr,
  input wire [7:0] periphBOut,
  input wire [7:0] periphBOe,
  input wire comparatorOneOutput,
  input wire comparatorTwoOutput,
  input wire clockOutLevel,
  output reg [7:0] analogEnA_q,
  output reg [7:0] analogEnB_q,
  output reg lowPowerWakeEnable_q,
  output reg comparatorRefOutEn_q,
  output reg firstTimerClockIn_q,
  output reg slaveSelectIn_q,
  output reg crystalPinsTaken_q,
  output reg clockInputTaken_q,
  output reg clockOutputTaken_q
);
  reg [7:0] latchA_q;
  reg [7:0] latchB_q;
  reg [7:0] dirA_q;
  reg [7:0] dirB_q;
  reg [7:0] anaLow_q;
  reg [5:0] anaHigh_q;
  reg [7:0] pwrCtrl_q;
  reg [2:0] oscCfg_q;
  reg [2:0] periphCtrl_q;
  reg [31:0] rdData_d;
  reg rdMiss_d;
  reg [7:0] bitMod_d;
  wire [7:0] rdA;
  wire [7:0] rdB;
  wire [7:0] anaMaskA;
  wire [7:0] anaMaskB;
  wire [7:0] ovrEnA;
  wire [7:0] ovrOutA;
  wire [7:0] ovrOeA;
  wire [7:0] forceOffA;
  wire [7:0] dirARead;
  wire xtalMode;
  wire clkInMode;
  wire clkOutMode;
  wire setupPh;
  wire accessWr;

  // register index of a byte address, 4'hf when unmapped
  function [3:0] regIndex;
    input [7:0] addr;
    begin
      case (addr)
        `GPDLM_OFS_PORT_A_DATA_DATA: regIndex = 4'h0;
        `GPDLM_OFS_PORT_A_DATA_DIR: regIndex = 4'h1;
        `GPDLM_OFS_ANA_LOW: regIndex = 4'h2;
        `GPDLM_OFS_PWR_CTRL: regIndex = 4'h3;
        `GPDLM_OFS_PORT_B_DATA_DATA: regIndex = 4'h4;
        `GPDLM_OFS_PORT_B_DATA_DIR: regIndex = 4'h5;
        `GPDLM_OFS_ANA_HIGH: regIndex = 4'h6;
        `GPDLM_OFS_OSC_CFG: regIndex = 4'h7;
        `GPDLM_OFS_PERIPH_CTRL: regIndex = 4'h8;
        `GPDLM_OFS_BIT_MODIFY: regIndex = 4'h9;
        default: regIndex = 4'hf;
      endcase
    end
  endfunction

  // oscillator pin ownership
  assign xtalMode = (oscCfg_q == `GPDLM_OSC_LP) || (oscCfg_q == `GPDLM_OSC_XT)
    || (oscCfg_q == `GPDLM_OSC_HS);
  assign clkInMode = xtalMode || (oscCfg_q == `GPDLM_OSC_EC)
    || (oscCfg_q == `GPDLM_OSC_RCIO) || (oscCfg_q == `GPDLM_OSC_RCCLKOUT);
  assign clkOutMode = (oscCfg_q == `GPDLM_OSC_INTCLKOUT)
    || (oscCfg_q == `GPDLM_OSC_RCCLKOUT);

  assign anaMaskA = {2'b00, anaLow_q[4], 1'b0, anaLow_q[3:0]};
  assign anaMaskB = {2'b00, anaHigh_q[5], anaHigh_q[3], anaHigh_q[1],
    anaHigh_q[0], anaHigh_q[2], anaHigh_q[4]};

  // comparator outputs and clock out take over pins
  assign ovrEnA = {1'b0, clkOutMode, periphCtrl_q[`GPDLM_PER_C2OE_BIT],
    periphCtrl_q[`GPDLM_PER_C1OE_BIT], 4'h0};
  assign ovrOutA = {1'b0, clockOutLevel, comparatorTwoOutput, comparatorOneOutput, 4'h0};
  assign ovrOeA = {1'b0, 1'b1, 1'b1, 1'b1, 4'h0};
  // input-only pin, oscillator pins, reference out
  assign forceOffA = {clkInMode, xtalMode, 2'b00, 1'b1,
    periphCtrl_q[`GPDLM_PER_COMPARATOR_REF_OUT_BIT], 2'b00};

  // crystal modes read direction 7:6 as one
  assign dirARead = xtalMode ? (dirA_q | 8'hc0) : dirA_q;

  gpdlm_pin_cell #(
    .WIDTH(8)
  ) uCellA (
    .core_clk(core_clk),
    .rstn(rstn),
    .latchVal(latchA_q),
    .dirVal(dirA_q),
    .anaMask(anaMaskA),
    .ovrEn(ovrEnA),
    .ovrOut(ovrOutA),
    .ovrOe(ovrOeA),
    .forceOff(forceOffA),
    .pinIn(pinAIn),
    .pinOut(pinAOut),
    .pinOe(pinAOe),
    .rdVal(rdA)
  );

  gpdlm_pin_cell #(
    .WIDTH(8)
  ) uCellB (
    .core_clk(core_clk),
    .rstn(rstn),
    .latchVal(latchB_q),
    .dirVal(dirB_q),
    .anaMask(anaMaskB),
    .ovrEn(periphBOvr),
    .ovrOut(periphBOut),
    .ovrOe(periphBOe),
    .forceOff(8'h00),
    .pinIn(pinBIn),
    .pinOut(pinBOut),
    .pinOe(pinBOe),
    .rdVal(rdB)
  );

  assign setupPh = psel && !penable;
  assign accessWr = psel && penable && pready && pwrite;

  // read mux returns pin levels for data
  always @*
  begin
    rdData_d = 32'h00000000;
    rdMiss_d = 1'b0;
    case (regIndex(paddr))
      4'h0: rdData_d[7:0] = rdA;
      4'h1: rdData_d[7:0] = dirARead;
      4'h2: rdData_d[7:0] = anaLow_q;
      4'h3: rdData_d[7:0] = pwrCtrl_q;
      4'h4: rdData_d[7:0] = rdB;
      4'h5: rdData_d[7:0] = dirB_q;
      4'h6: rdData_d[5:0] = anaHigh_q;
      4'h7: rdData_d[2:0] = oscCfg_q;
      4'h8: rdData_d[2:0] = periphCtrl_q;
      4'h9: rdData_d = 32'h00000000;
      default: rdMiss_d = 1'b1;
    endcase
  end

  // bit modify from sampled pin levels
  always @*
  begin
    bitMod_d = pwdata[`GPDLM_BM_PORT_BIT] ? rdB : rdA;
    bitMod_d[pwdata[`GPDLM_BM_IDX_MSB:0]] = pwdata[`GPDLM_BM_VAL_BIT];
  end

  // apb answer, one wait-free access phase
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (setupPh)
    begin
      pready <= 1'b1;
      pslverr <= rdMiss_d;
      prdata <= pwrite ? 32'h00000000 : rdData_d;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // register writes
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      latchA_q <= `GPDLM_RST_LATCH;
      latchB_q <= `GPDLM_RST_LATCH;
      dirA_q <= `GPDLM_RST_DIR;
      dirB_q <= `GPDLM_RST_DIR;
      anaLow_q <= `GPDLM_RST_ANA_LOW;
      anaHigh_q <= `GPDLM_RST_ANA_HIGH;
      pwrCtrl_q <= `GPDLM_RST_PWR;
      oscCfg_q <= `GPDLM_RST_OSC;
      periphCtrl_q <= `GPDLM_RST_PERIPH;
    end
    else if (accessWr && pstrb[0])
    begin
      case (regIndex(paddr))
        4'h0: latchA_q <= pwdata[7:0];
        4'h1: dirA_q <= pwdata[7:0];
        4'h2: anaLow_q <= pwdata[7:0];
        4'h3: pwrCtrl_q <= pwdata[7:0] & `GPDLM_PWR_MASK;
        4'h4: latchB_q <= pwdata[7:0];
        4'h5: dirB_q <= pwdata[7:0];
        4'h6: anaHigh_q <= pwdata[5:0];
        4'h7: oscCfg_q <= pwdata[2:0];
        4'h8: periphCtrl_q <= pwdata[2:0];
        // read value with the indexed bit replaced stored into latch
        4'h9:
        begin
          if (pwdata[`GPDLM_BM_PORT_BIT])
            latchB_q <= bitMod_d;
          else
            latchA_q <= bitMod_d;
        end
        default: oscCfg_q <= oscCfg_q;
      endcase
    end
  end

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      analogEnA_q <= 8'h00;
      analogEnB_q <= 8'h00;
      lowPowerWakeEnable_q <= 1'b0;
      comparatorRefOutEn_q <= 1'b0;
      firstTimerClockIn_q <= 1'b0;
      slaveSelectIn_q <= 1'b0;
      crystalPinsTaken_q <= 1'b0;
      clockInputTaken_q <= 1'b0;
      clockOutputTaken_q <= 1'b0;
    end
    else
    begin
      analogEnA_q <= anaMaskA;
      analogEnB_q <= anaMaskB;
      lowPowerWakeEnable_q <= pwrCtrl_q[`GPDLM_PWR_WAKE_BIT];
      comparatorRefOutEn_q <= periphCtrl_q[`GPDLM_PER_COMPARATOR_REF_OUT_BIT];
      firstTimerClockIn_q <= rdA[4];
      slaveSelectIn_q <= rdA[5];
      crystalPinsTaken_q <= xtalMode;
      clockInputTaken_q <= clkInMode;
      clockOutputTaken_q <= clkOutMode;
    end
  end
endmodule // gpdlm_port

// File: gpdlm_port_chk.sv
`timescale 1ns/10ps
module gpdlm_port_chk (
  input wire core_clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [7:0] pinAOe,
  input wire [7:0] pinBIn,
  input wire [7:0] pinBOut,
  input wire [7:0] pinBOe,
  input wire [7:0] periphBOvr,
  input wire [7:0] periphBOe,
  input wire [7:0] analogEnB_q,
  input wire crystalPinsTaken_q,
  input wire clockOutputTaken_q
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  wire wrB = psel && penable && pready && pwrite && pstrb[0] && periphBOvr == 8'h00;
  wire rqRd = psel && !penable && !pwrite;
  wire [7:0] wrByte = pwdata[7:0];
  wire [7:0] digB = pinBIn & ~analogEnB_q;
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  unmapped_err_a: assert property (psel && !penable && paddr > 8'h24 |=> pslverr && prdata == 0)
    else $error("unmapped access accepted");
  dir_drive_a: assert property (wrB && paddr == 8'h14 |-> ##2 pinBOe == ~$past(wrByte, 2))
    else $error("driver enable not from direction");
  latch_drive_a: assert property (wrB && paddr == 8'h10 |-> ##2
    (pinBOut & pinBOe) == ($past(wrByte, 2) & pinBOe)) else $error("pin not driven from latch");
  pin_read_a: assert property (rqRd && paddr == 8'h10 && $stable(digB)
    |=> prdata[7:0] == $past(digB)) else $error("port read mismatch");
  xtal_dir_a: assert property (rqRd && paddr == 8'h04 && crystalPinsTaken_q
    |=> prdata[7:6] == 2'b11) else $error("upper direction bits not one");
  xtal_pins_a: assert property (crystalPinsTaken_q && $past(crystalPinsTaken_q)
    |-> pinAOe[7:6] == 2'b00) else $error("crystal pins driven");
  clk_out_a: assert property (clockOutputTaken_q && $past(clockOutputTaken_q) |-> pinAOe[6])
    else $error("clock output not driven");
  input_only_a: assert property (!pinAOe[3])
    else $error("input only pin driven");
  periph_own_a: assert property ($stable(periphBOvr) && $stable(periphBOe)
    |-> ((pinBOe ^ periphBOe) & periphBOvr) == 8'h00) else $error("takeover ignored");
  cover property (wrB && paddr == 8'h24);
  cover property (periphBOvr != 8'h00);
  cover property (crystalPinsTaken_q && rqRd);
endmodule // gpdlm_port_chk
bind gpdlm_port gpdlm_port_chk i_gpdlm_port_chk (.core_clk, .rstn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pinAOe, .pinBIn, .pinBOut, .pinBOe,
  .periphBOvr, .periphBOe, .analogEnB_q, .crystalPinsTaken_q, .clockOutputTaken_q);

// File: gpdlm_pin_model.sv
`timescale 1ns/10ps
module gpdlm_pin_model (
  input wire [7:0] drvA,
  input wire [7:0] enA,
  input wire [7:0] farA,
  input wire [7:0] drvB,
  input wire [7:0] enB,
  input wire [7:0] farB,
  output wire [7:0] lvlA,
  output wire [7:0] lvlB
);
  // released pins follow the far side pattern
  assign lvlA = (enA & drvA) | (~enA & farA);
  assign lvlB = (enB & drvB) | (~enB & farB);
endmodule // gpdlm_pin_model

// File: gpio_port_dir_latch_mux_tb.sv
`timescale 1ns/10ps
module gpio_port_dir_latch_mux_tb;
  logic core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic c1 = 1'b0, c2 = 1'b0;
  logic [7:0] paddr = 8'h00, farB = 8'h00, ovr = 8'h00, pOut = 8'h00, pOe = 8'h00;
  logic [31:0] pwdata = 32'h0, r;
  logic [7:0] rdv, d, e, a;
  logic [5:0] h;
  wire [31:0] prdata;
  wire pready, pslverr, lpw;
  wire [7:0] pinAIn, pinAOut, pinAOe, pinBIn, pinBOut, pinBOe;
  integer err_total = 0, check_count = 0, seed = 7636, i, n;
  always #25 core_clk = ~core_clk;
  gpdlm_port i_gpdlm_port (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pinAIn(pinAIn), .pinAOut(pinAOut), .pinAOe(pinAOe),
    .pinBIn(pinBIn), .pinBOut(pinBOut), .pinBOe(pinBOe), .periphBOvr(ovr), .periphBOut(pOut),
    .periphBOe(pOe), .comparatorOneOutput(c1), .comparatorTwoOutput(c2), .clockOutLevel(1'b1),
    .analogEnA_q(), .analogEnB_q(), .lowPowerWakeEnable_q(lpw), .comparatorRefOutEn_q(),
    .firstTimerClockIn_q(), .slaveSelectIn_q(), .crystalPinsTaken_q(), .clockInputTaken_q(),
    .clockOutputTaken_q());
  gpdlm_pin_model i_gpdlm_pin_model (.drvA(pinAOut), .enA(pinAOe), .farA(8'h5a),
    .drvB(pinBOut), .enB(pinBOe), .farB(farB), .lvlA(pinAIn), .lvlB(pinBIn));
  function logic [7:0] bmask(input logic [5:0] s);
    bmask = {2'b00, s[5], s[3], s[1], s[0], s[2], s[4]};
  endfunction
  task check(input logic [7:0] seen, input logic [7:0] exp);
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] ad, input logic [15:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {16'h0, v};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n = n + 1;
    end
    while (pready !== 1'b1 && n < 16);
    rdv = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
    // pins launch on the edge above, so let them settle one more edge
    @(posedge core_clk);
    if (n == 16)
    begin
      err_total = err_total + 1;
      end_sim;
    end
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    for (a = 8'h04; a < 8'h2c; a = a + 8'h04)
    begin
      bus(1'b0, a, 16'h0);
      e = (a == 8'h18) ? 8'h3f : (a == 8'h1c) ? 8'h04
        : (a == 8'h04 || a == 8'h14 || a == 8'h08) ? 8'hff : 8'h00;
      if (a != 8'h10)
        check(rdv, e);
    end
    for (i = 0; i < 24; i = i + 1)
    begin
      r = $random(seed);
      farB <= r[7:0];
      h = (i < 6) ? 6'h00 : r[29:24];
      d = r[15:8] | bmask(h);
      bus(1'b1, 8'h18, {10'h0, h});
      bus(1'b1, 8'h14, {8'h0, d});
      bus(1'b1, 8'h10, {8'h0, r[23:16]});
      bus(1'b0, 8'h10, 16'h0);
      e = ((~d & r[23:16]) | (d & r[7:0])) & ~bmask(h);
      check(rdv, e);
      check(pinBOe, ~d);
      bus(1'b1, 8'h24, {8'h01, 4'h0, r[27:24]});
      e = (e & ~(8'h01 << r[26:24])) | ({7'h0, r[27]} << r[26:24]);
      check(pinBOut & ~d, e & ~d);
    end
    for (i = 0; i < 6; i = i + 1)
    begin
      r = $random(seed);
      ovr <= r[7:0];
      pOe <= r[15:8];
      pOut <= r[23:16];
      repeat (3) @(posedge core_clk);
      check(pinBOe, (r[15:8] & r[7:0]) | (~d & ~r[7:0]));
      check(pinBOut & pinBOe & r[7:0], r[23:16] & r[15:8] & r[7:0]);
    end
    ovr <= 8'h00;
    bus(1'b1, 8'h08, 16'h0);
    bus(1'b1, 8'h04, 16'h0);
    for (i = 0; i < 8; i = i + 1)
    begin
      bus(1'b1, 8'h1c, i[15:0]);
      bus(1'b0, 8'h04, 16'h0);
      check(rdv, (i < 3) ? 8'hc0 : 8'h00);
      check(pinAOe, {i == 4 || i == 5, i > 2, 6'h37});
    end
    bus(1'b1, 8'h1c, 16'h4);
    c1 <= r[0];
    c2 <= r[1];
    bus(1'b1, 8'h04, 16'hff);
    bus(1'b1, 8'h20, 16'h3);
    check(pinAOe & 8'h30, 8'h30);
    check(pinAOut & 8'h30, {2'b00, c2, c1, 4'h0});
    bus(1'b1, 8'h04, 16'h0);
    bus(1'b1, 8'h20, 16'h4);
    check(pinAOe, 8'hf3);
    bus(1'b1, 8'h0c, 16'hff);
    bus(1'b0, 8'h0c, 16'h0);
    check(rdv, 8'h33);
    check({7'h0, lpw}, 8'h01);
    end_sim;
  end
endmodule // gpio_port_dir_latch_mux_tb
